/* File: core/pmic_control_enable_regs.sv */
// Purpose: Control, flag, key and enable registers of the power manager.
// Assumes: Register requests arrive one cycle wide from the serial slave.
// Notes: Seal breaking happens elsewhere; this bank only reads its status.
//   A failing supply overrides both the sequencer and software in the same cycle.
//   The key opens exactly one following write, so a stray write closes it again.
//   Buck e and f clears by register write are refused once the seal is broken, not silently queued.
//   The measurement trigger reads back as 0 because it clears the cycle after.
`timescale 1ns/100ps
`default_nettype none
module pmic_control_enable_regs
  import pmic_regs_pkg::*;
#(
  parameter logic [7:0] UNLOCK_KEY_VALUE = UNLOCK_KEY_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire seq_cmd_t seq,
  input wire logic powerfail_comp_out_n,
  input wire logic factory_seal_status,
  input wire logic [2:0] out_alt_select,
  output logic coincell_measure_start,
  output logic powerfail_shutdown,
  output power_state_t power_state,
  output logic [5:0] buck_enables,
  output logic [6:0] switch_output_enables,
  output logic [2:0] out_pin_out,
  output logic [2:0] out_pin_oe
);

  logic [1:0] control;
  logic [7:0] suspend_rail_flags;
  logic key_ok;
  logic [7:0] suspend_snapshot;
  logic shutdown_now;
  logic write_buck;
  logic write_switch;
  logic [5:0] next_buck;
  logic write_control;
  logic write_key;
  logic leaving_suspend;
  logic leaving_off;
  logic sequencer_step;
  logic [7:0] merged_buck;
  logic [7:0] merged_switch;
  logic [5:0] next_buck_enables;
  logic [6:0] next_switch_output_enables;
  logic [7:0] next_suspend_rail_flags;
  power_state_t next_power_state;

  // General-output level bits sit above the switch and linear enables.
  localparam int OUT_LEVEL_LSB = 4;
  localparam int OUT_COUNT = 3;

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [1:0] ctl,
      input logic [7:0] flags, input logic [5:0] bucks, input logic [6:0] sw);
    case (addr)
      ADDR_POWER_CONTROL: read_mux = {6'h00, ctl};
      ADDR_SUSPEND_RAIL_FLAGS: read_mux = flags;
      ADDR_UNLOCK_KEY: read_mux = READ_ZERO;
      ADDR_BUCK_ENABLES: read_mux = {2'h0, bucks};
      ADDR_SWITCH_OUTPUT_ENABLES: read_mux = {1'h0, sw};
      default: read_mux = READ_ZERO;
    endcase
  endfunction

  // Every write strobe below decodes its own sub-address through this one helper.
  function automatic logic write_hit(input reg_req_t r, input logic [7:0] addr);
    write_hit = r.wr && r.addr == addr;
  endfunction

  // The sequencer owns only the bits in its mask; software keeps the rest.
  function automatic logic [7:0] seq_merge(input logic [7:0] cur, input logic [7:0] value,
      input logic [7:0] mask);
    seq_merge = (cur & ~mask) | (value & mask);
  endfunction

  // The comparator is active low, so a low level while armed forces OFF.
  assign shutdown_now = control[POWERFAIL_SHUTDOWN_EN_BIT] && !powerfail_comp_out_n;
  assign write_control = write_hit(req, ADDR_POWER_CONTROL);
  assign write_key = write_hit(req, ADDR_UNLOCK_KEY);
  assign write_buck = write_hit(req, ADDR_BUCK_ENABLES) && key_ok;
  assign write_switch = write_hit(req, ADDR_SWITCH_OUTPUT_ENABLES) && key_ok;
  // A power-up that loses to a shutdown in the same cycle never happened, so it
  // must not disturb the enables or the flags either.
  assign sequencer_step = (seq.power_up || seq.power_down) && !shutdown_now;
  assign leaving_suspend = seq.power_up && power_state == PWR_SUSPEND && !shutdown_now;
  assign leaving_off = seq.power_up && power_state == PWR_OFF && !shutdown_now;

  // A cleared bit for bucks e and f is accepted only while the seal is fresh.
  always_comb begin
    next_buck = req.wdata[5:0];
    if (factory_seal_status) begin
      next_buck[BUCK_F_BIT] = req.wdata[BUCK_F_BIT] | buck_enables[BUCK_F_BIT];
      next_buck[BUCK_E_BIT] = req.wdata[BUCK_E_BIT] | buck_enables[BUCK_E_BIT];
    end
  end

  // The trigger bit is stored for one cycle only, so a read never sees it stuck high.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control <= 2'h0;
    end else if (write_control) begin
      control[POWERFAIL_SHUTDOWN_EN_BIT] <= req.wdata[POWERFAIL_SHUTDOWN_EN_BIT];
      control[COINCELL_MEASURE_START_BIT] <= req.wdata[COINCELL_MEASURE_START_BIT];
    end else begin
      control[COINCELL_MEASURE_START_BIT] <= 1'b0;
    end
  end

  // One-cycle trigger to the measurement engine; a written 0 never fires it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coincell_measure_start <= 1'b0;
    end else begin
      coincell_measure_start <= write_control && req.wdata[COINCELL_MEASURE_START_BIT];
    end
  end

  // Key access holds only for the very next register write.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_ok <= 1'b0;
    end else if (req.wr) begin
      key_ok <= write_key && req.wdata == UNLOCK_KEY_VALUE;
    end
  end

  // Shutdown is checked first so that a sequencer request cannot revive a failing supply.
  always_comb begin
    next_power_state = power_state;
    if (shutdown_now) begin
      next_power_state = PWR_OFF;
    end else begin
      case (power_state)
        PWR_OFF: begin
          if (seq.power_up) begin
            next_power_state = PWR_ACTIVE;
          end
        end
        PWR_ACTIVE: begin
          if (seq.power_down) begin
            next_power_state = PWR_OFF;
          end else if (seq.suspend_enter) begin
            next_power_state = PWR_SUSPEND;
          end
        end
        PWR_SUSPEND: begin
          if (seq.power_up) begin
            next_power_state = PWR_ACTIVE;
          end else if (seq.power_down) begin
            next_power_state = PWR_OFF;
          end
        end
        default: next_power_state = PWR_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_state <= PWR_OFF;
    end else begin
      power_state <= next_power_state;
    end
  end

  // Registered so that the shutdown report lines up with the rails already being off.
  // The report rises at the same edge that clears the enables.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerfail_shutdown <= 1'b0;
    end else begin
      powerfail_shutdown <= shutdown_now;
    end
  end

  // Enabled outputs are those released high, so the level bit itself is the snapshot.
  assign suspend_snapshot = {switch_output_enables[6:4], switch_output_enables[0],
                             buck_enables[3:0]};

  // The snapshot is taken from the enables as they stood through the suspend, before
  // the sequencer rewrites them at the same edge.
  always_comb begin
    next_suspend_rail_flags = suspend_rail_flags;
    if (leaving_suspend) begin
      next_suspend_rail_flags = suspend_snapshot;
    end else if (leaving_off) begin
      next_suspend_rail_flags = RESET_VALUE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      suspend_rail_flags <= RESET_VALUE;
    end else begin
      suspend_rail_flags <= next_suspend_rail_flags;
    end
  end

  // Shutdown beats the sequencer, which beats a register write in the same cycle.
  assign merged_buck = seq_merge({2'h0, buck_enables}, seq.buck_value, SEQ_BUCK_MASK);
  always_comb begin
    next_buck_enables = buck_enables;
    if (shutdown_now) begin
      next_buck_enables = 6'h00;
    end else if (sequencer_step) begin
      next_buck_enables = merged_buck[5:0];
    end else if (write_buck) begin
      next_buck_enables = next_buck & BUCK_MASK[5:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buck_enables <= 6'h00;
    end else begin
      buck_enables <= next_buck_enables;
    end
  end

  // A shutdown leaves the general-output levels alone; they are not supply rails.
  assign merged_switch = seq_merge({1'h0, switch_output_enables}, seq.switch_value,
                                   SEQ_SWITCH_MASK);
  always_comb begin
    next_switch_output_enables = switch_output_enables;
    if (shutdown_now) begin
      next_switch_output_enables = {switch_output_enables[6:4], 4'h0};
    end else if (sequencer_step) begin
      next_switch_output_enables = merged_switch[6:0];
    end else if (write_switch) begin
      next_switch_output_enables = req.wdata[6:0] & SWITCH_MASK[6:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switch_output_enables <= 7'h00;
    end else begin
      switch_output_enables <= next_switch_output_enables;
    end
  end

  // Open-drain outputs: 0 pulls low, 1 releases; alternate function releases too.
  // The pad never drives high, so a released output rests at its external pull-up.
  generate
    for (genvar i = 0; i < OUT_COUNT; i++) begin : g_open_drain
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          out_pin_out[i] <= 1'b0;
          out_pin_oe[i] <= 1'b0;
        end else begin
          out_pin_out[i] <= 1'b0;
          out_pin_oe[i] <= !switch_output_enables[OUT_LEVEL_LSB + i] &&
                           !out_alt_select[i];
        end
      end
    end
  endgenerate

  // Reads are registered so that rdata stands until the next read; writes never
  // disturb it, which lets a slow serial slave pick the byte up at leisure.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= RESET_VALUE;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= read_mux(req.addr, control, suspend_rail_flags, buck_enables,
                          switch_output_enables);
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/pmic_regs_pkg.sv */
// Purpose: Shared constants and types for the power-control register bank.
// Assumes: 8-bit sub-addresses and 8-bit register data.
// Notes: Offsets and field positions are used by the bank and its bench.
package pmic_regs_pkg;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h06;
  localparam logic [7:0] ADDR_SUSPEND_RAIL_FLAGS = 8'h07;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h10;
  localparam logic [7:0] ADDR_BUCK_ENABLES = 8'h11;
  localparam logic [7:0] ADDR_SWITCH_OUTPUT_ENABLES = 8'h12;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] UNLOCK_KEY_DEFAULT = 8'h5A;
  localparam int POWERFAIL_SHUTDOWN_EN_BIT = 1;
  localparam int COINCELL_MEASURE_START_BIT = 0;
  localparam int BUCK_F_BIT = 5;
  localparam int BUCK_E_BIT = 4;
  localparam logic [7:0] CONTROL_MASK = 8'h03;
  localparam logic [7:0] BUCK_MASK = 8'h3F;
  localparam logic [7:0] SWITCH_MASK = 8'h7F;
  localparam logic [7:0] SEQ_BUCK_MASK = 8'h1F;
  localparam logic [7:0] SEQ_SWITCH_MASK = 8'h03;

  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_ACTIVE,
    PWR_SUSPEND
  } power_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic power_up;
    logic power_down;
    logic suspend_enter;
    logic [7:0] buck_value;
    logic [7:0] switch_value;
  } seq_cmd_t;
endpackage

/* File: verification/pmic_host_model.sv */
// Purpose: Host on the register bus. Assumes: One request at a time. Notes: Pulsed requests.
`timescale 1ns/100ps
`default_nettype none
module pmic_host_model
  import pmic_regs_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output reg_req_t req
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  // A missing answer returns unknown so that the caller's compare fails.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rvalid ? rdata : 8'hXX;
  endtask
endmodule
`default_nettype wire

/* File: verification/pmic_regs_monitor.sv */
// Purpose: Port checker. Assumes: One clock. Notes: Bound to the bank.
`timescale 1ns/100ps
`default_nettype none
module pmic_regs_monitor
  import pmic_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic coincell_measure_start,
  input wire logic powerfail_shutdown,
  input wire power_state_t power_state,
  input wire logic [5:0] buck_enables,
  input wire logic [6:0] switch_output_enables,
  input wire logic [2:0] out_pin_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_read(a);
    req.rd && req.addr == a;
  endsequence
  sequence s_trig;
    req.wr && req.addr == ADDR_POWER_CONTROL && req.wdata[0];
  endsequence
  a_read_answer: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  a_key_hidden: assert property (s_read(ADDR_UNLOCK_KEY) |=> rdata == 8'h00)
    else $error("key readable");
  a_ctl_reserved: assert property (s_read(ADDR_POWER_CONTROL) |=> rdata[7:2] == 6'h00)
    else $error("control reserved set");
  a_buck_reserved: assert property (s_read(ADDR_BUCK_ENABLES) |=> rdata[7:6] == 2'h0)
    else $error("buck reserved set");
  a_sw_reserved: assert property (s_read(ADDR_SWITCH_OUTPUT_ENABLES) |=> !rdata[7])
    else $error("switch reserved set");
  a_trigger_fires: assert property (s_trig |=> coincell_measure_start)
    else $error("no measurement");
  a_trigger_cause: assert property (coincell_measure_start |-> $past(req.wr
    && req.addr == ADDR_POWER_CONTROL && req.wdata[0])) else $error("stray measurement");
  a_pf_all_off: assert property (powerfail_shutdown |-> power_state == PWR_OFF
    && buck_enables == 6'h00 && switch_output_enables[3:0] == 4'h0) else $error("rails on");
  a_open_drain: assert property (out_pin_out == 3'h0)
    else $error("output driven high");
endmodule
bind pmic_control_enable_regs pmic_regs_monitor u_pmic_regs_monitor (.clk, .rst, .req, .rdata,
  .rvalid, .coincell_measure_start, .powerfail_shutdown, .power_state, .buck_enables,
  .switch_output_enables, .out_pin_out);
`default_nettype wire

/* File: verification/test_pmic_control_enable_regs.sv */
// Purpose: Self-checking bench. Assumes: 50 MHz clock. Notes: Fixed LFSR seed.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module test_pmic_control_enable_regs
  import pmic_regs_pkg::*;
;
  logic clk = 0, rst = 1, powerfail_comp_out_n = 1, factory_seal_status = 0;
  logic [2:0] out_alt_select = 0, out_pin_out, out_pin_oe;
  seq_cmd_t seq = '0;
  reg_req_t req;
  logic [7:0] rdata, d, v, w, bv;
  logic rvalid, coincell_measure_start, powerfail_shutdown;
  power_state_t power_state;
  logic [5:0] buck_enables;
  logic [6:0] switch_output_enables;
  logic [31:0] rng = 32'h5caa7c45;
  logic [7:0] addrs [6] = '{8'h06, 8'h07, 8'h10, 8'h11, 8'h12, 8'h3C};
  int errors = 0, total_checks = 0;
  always #10 clk = ~clk;
  pmic_host_model u_pmic_host_model (.clk, .rdata, .rvalid, .req);
  pmic_control_enable_regs u_pmic_control_enable_regs (.clk, .rst, .req, .rdata, .rvalid, .seq,
    .powerfail_comp_out_n, .factory_seal_status, .out_alt_select, .coincell_measure_start,
    .powerfail_shutdown, .power_state, .buck_enables, .switch_output_enables, .out_pin_out,
    .out_pin_oe);
  function automatic logic [7:0] rnd();
    rng = {rng[30:0], rng[31] ^ rng[21] ^ rng[1] ^ rng[0]};
    return rng[7:0];
  endfunction
  function automatic logic [7:0] flags_of(input logic [5:0] b, input logic [6:0] s);
    return {s[6:4], s[0], b[3:0]};
  endfunction
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    u_pmic_host_model.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic prot(input logic [7:0] a, input logic [7:0] x);
    u_pmic_host_model.wr(ADDR_UNLOCK_KEY, UNLOCK_KEY_DEFAULT);
    u_pmic_host_model.wr(a, x);
    @(negedge clk);
  endtask
  task automatic pulse(input logic u, input logic n, input logic s, input logic [7:0] b, x);
    @(posedge clk);
    seq <= '{u, n, s, b, x};
    @(posedge clk);
    seq <= '0;
    @(negedge clk);
  endtask
  task automatic wrap_up();
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #50000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    foreach (addrs[i]) chk_rd(addrs[i], 8'h00);
    u_pmic_host_model.wr(ADDR_BUCK_ENABLES, 8'h3F);
    chk_rd(ADDR_BUCK_ENABLES, 8'h00);
    bv = rnd();
    pulse(1, 0, 0, bv, 8'hFF);
    `CHK(buck_enables, {1'b0, bv[4:0]})
    `CHK(switch_output_enables, 7'h03)
    chk_rd(ADDR_SUSPEND_RAIL_FLAGS, 8'h00);
    v = rnd() | 8'h20;
    prot(ADDR_BUCK_ENABLES, v);
    `CHK(buck_enables, v[5:0])
    w = rnd();
    out_alt_select <= rng[10:8];
    prot(ADDR_SWITCH_OUTPUT_ENABLES, w);
    `CHK(switch_output_enables, w[6:0])
    chk_rd(ADDR_SWITCH_OUTPUT_ENABLES, {1'b0, w[6:0]});
    `CHK(out_pin_oe, ~w[6:4] & ~out_alt_select)
    prot(ADDR_UNLOCK_KEY, rnd());
    chk_rd(ADDR_UNLOCK_KEY, 8'h00);
    pulse(0, 0, 1, 8'h00, 8'h00);
    pulse(1, 0, 0, bv, 8'h00);
    `CHK(power_state, PWR_ACTIVE)
    chk_rd(ADDR_SUSPEND_RAIL_FLAGS, flags_of(v[5:0], w[6:0]));
    factory_seal_status <= 1;
    prot(ADDR_BUCK_ENABLES, 8'h00);
    `CHK(buck_enables, {v[5], bv[4], 4'h0})
    factory_seal_status <= 0;
    pulse(0, 1, 0, 8'h00, 8'h00);
    `CHK(buck_enables, {v[5], 5'h00})
    pulse(1, 0, 0, bv, 8'h00);
    powerfail_comp_out_n <= 0;
    repeat (3) @(negedge clk);
    `CHK(power_state, PWR_ACTIVE)
    powerfail_comp_out_n <= 1;
    u_pmic_host_model.wr(ADDR_POWER_CONTROL, 8'hFF);
    chk_rd(ADDR_POWER_CONTROL, 8'h02);
    powerfail_comp_out_n <= 0;
    repeat (2) @(negedge clk);
    `CHK(power_state, PWR_OFF)
    `CHK(buck_enables, 6'h00)
    powerfail_comp_out_n <= 1;
    pulse(1, 0, 0, bv, 8'h00);
    chk_rd(ADDR_SUSPEND_RAIL_FLAGS, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
